// ==== hw/pidc_params.svh ====
`ifndef PIDC_PARAMS_SVH
`define PIDC_PARAMS_SVH

// data word width and fraction bits of the signed fixed-point format
`define PIDC_WIDTH        32
`define PIDC_FRAC         16

// status word bit positions
`define PIDC_ST_SKIP      0
`define PIDC_ST_PV_LIM    2
`define PIDC_ST_MV_LIM    3
`define PIDC_ST_OUTPUT_UPPER_CLAMP    4
`define PIDC_ST_OUTPUT_LOWER_CLAMP    5
`define PIDC_ST_BUSY      8
`define PIDC_ST_WINDUP    15

// fewest clock cycles one sample must span for a full computation
`define PIDC_MIN_CYCLES   32'h0000_0068

// reset values
`define PIDC_RST_STATUS   16'h0000
`define PIDC_RST_WORD     32'h0000_0000

`endif

// ==== hw/pidc_pkg.sv ====
package pidc_pkg;

   typedef enum logic [3:0] {
      PIDC_IDLE   = 4'h1,
      PIDC_INTEG  = 4'h2,
      PIDC_DERIV  = 4'h4,
      PIDC_OUTPUT = 4'h8
   } pidc_state_t;

endpackage : pidc_pkg

// ==== hw/pidc_div_if.sv ====
`timescale 1ns/1ps

interface pidc_div_if #(
   parameter int W = 32
);
   logic                start;
   logic signed [W-1:0] num;
   logic signed [W-1:0] den;
   logic                done;
   logic signed [W-1:0] quo;

   modport client (output start, output num, output den, input done, input quo);
   modport server (input start, input num, input den, output done, output quo);
endinterface : pidc_div_if

// ==== hw/pidc_divider.sv ====
`timescale 1ns/1ps
`include "pidc_params.svh"

// sequential signed fixed-point divide: quo = (num << F) / den
module pidc_divider
   import pidc_pkg::*;
#(
   parameter int W = `PIDC_WIDTH,
   parameter int F = `PIDC_FRAC
) (
   input wire logic    clk,
   input wire logic    rst,
   pidc_div_if.server  dv
);
   localparam int N  = W + F;
   localparam int CW = $clog2(N + 1);

   logic [N-1:0]  sh_q;
   logic [W:0]    rem_q;
   logic [W-1:0]  den_q;
   logic [CW-1:0] cnt_q;
   logic          neg_q;
   logic          busy_q;
   logic          done_q;
   logic [W:0]    trial;
   logic [W-1:0]  num_abs;
   logic [W-1:0]  den_abs;

   assign num_abs = dv.num[W-1] ? W'(-dv.num) : W'(dv.num);
   assign den_abs = dv.den[W-1] ? W'(-dv.den) : W'(dv.den);
   assign trial   = {rem_q[W-1:0], sh_q[N-1]};
   assign dv.done = done_q;
   assign dv.quo  = neg_q ? W'(-sh_q[W-1:0]) : W'(sh_q[W-1:0]);

   always_ff @(posedge clk) begin
      if (rst) begin
         sh_q   <= '0;
         rem_q  <= '0;
         den_q  <= '0;
         cnt_q  <= '0;
         neg_q  <= 1'b0;
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         done_q <= busy_q && (cnt_q == CW'(1));
         if (dv.start && !busy_q) begin
            sh_q   <= {num_abs, {F{1'b0}}};
            rem_q  <= '0;
            den_q  <= den_abs;
            cnt_q  <= CW'(N);
            neg_q  <= dv.num[W-1] ^ dv.den[W-1];
            busy_q <= 1'b1;
         end else if (busy_q) begin
            if (trial >= {1'b0, den_q}) begin
               rem_q <= trial - {1'b0, den_q};
               sh_q  <= {sh_q[N-2:0], 1'b1};
            end else begin
               rem_q <= trial;
               sh_q  <= {sh_q[N-2:0], 1'b0};
            end
            cnt_q <= cnt_q - CW'(1);
            if (cnt_q == CW'(1)) begin
               busy_q <= 1'b0;
            end
         end
      end
   end

endmodule : pidc_divider

// ==== hw/pidc_loop.sv ====
`timescale 1ns/1ps
`include "pidc_params.svh"

// Functional notes
// - compute only while execute high; flag normal
// - gain multiplies sum of all three terms
// - zero gain means no control at all
// - integral divided by time; zero omits it
// - derivative times time; zero omits it
// - limit measurement step; zero limit disables
// - limit output step; zero limit disables
// - output above upper clamp only when clamps cross
// - output below lower clamp only when clamps cross
// - derivative source: low measurement, high error
// - guard disable high turns anti-windup off
// - status bits follow conditions; low abnormal
// - bit 0 while period too small
// - bits 2,3 while measurement/output limited
// - bits 4,5 while at upper/lower clamp
// - bit 8 computing, bit 15 windup acting
module pidc_loop
   import pidc_pkg::*;
#(
   parameter int W = `PIDC_WIDTH,
   parameter int F = `PIDC_FRAC
) (
   input  wire logic                CLK,
   input  wire logic                RST,
   input  wire logic                EXECUTE,
   input  wire logic signed [W-1:0] SETPOINT_VALUE,
   input  wire logic signed [W-1:0] MEASURED_VALUE,
   input  wire logic signed [W-1:0] GAIN_P,
   input  wire logic signed [W-1:0] TIME_I,
   input  wire logic signed [W-1:0] TIME_D,
   input  wire logic signed [W-1:0] OUTPUT_STEP_LIMIT,
   input  wire logic signed [W-1:0] OUTPUT_UPPER_CLAMP,
   input  wire logic signed [W-1:0] OUTPUT_LOWER_CLAMP,
   input  wire logic signed [W-1:0] MEASUREMENT_STEP_LIMIT,
   input  wire logic                WINDUP_GUARD_DISABLE,
   input  wire logic                DERIV_ON_ERROR,
   input  wire logic [31:0]         SAMPLE_CYCLES,
   input  wire logic signed [W-1:0] SAMPLE_TIME,
   output logic                     NORMAL_OPERATION_FLAG,
   output logic [15:0]              STATUS,
   output logic signed [W-1:0]      CONTROL_OUTPUT
);

   pidc_div_if #(.W(W)) div_bus ();

   pidc_divider #(.W(W), .F(F)) u_div (
      .clk (CLK),
      .rst (RST),
      .dv  (div_bus)
   );

   pidc_state_t         state_q;
   logic [31:0]         tick_cnt_q;
   logic                tick;
   logic                skip;
   logic                req_q;
   logic signed [W-1:0] pv_prev_q;
   logic signed [W-1:0] dsrc_prev_q;
   logic signed [W-1:0] err_q;
   logic signed [W-1:0] delta_q;
   logic signed [W-1:0] acc_q;
   logic signed [W-1:0] acc_cand_q;
   logic signed [W-1:0] i_term_q;
   logic signed [W-1:0] d_term_q;
   logic signed [W-1:0] mv_q;
   logic [15:0]         stat_q;
   logic                pv_lim_q;

   // front-end combinational values
   logic signed [W-1:0] dpv;
   logic signed [W-1:0] pv_used;
   logic                pv_lim;
   logic signed [W-1:0] err;
   logic signed [W-1:0] dsrc;
   // output-stage combinational values
   logic signed [W-1:0] raw;
   logic signed [W-1:0] dmv;
   logic signed [W-1:0] stepped;
   logic signed [W-1:0] mv_d;
   logic                mv_lim;
   logic                at_max;
   logic                at_min;
   logic                windup;

   function automatic logic signed [W-1:0] fmul(input logic signed [W-1:0] a, input logic signed [W-1:0] b);
      logic signed [2*W-1:0] p;
      p = a * b;
      return p[F+W-1:F];
   endfunction : fmul

   assign skip = SAMPLE_CYCLES < `PIDC_MIN_CYCLES;
   assign tick = EXECUTE && !skip && (tick_cnt_q == 32'h0000_0000);

   // sample period divider
   // a period below the minimum parks the counter, so every sample is skipped
   always_ff @(posedge CLK) begin
      if (RST) begin
         tick_cnt_q <= 32'h0000_0000;
      end else if (!EXECUTE || skip || tick_cnt_q == 32'h0000_0000) begin
         tick_cnt_q <= (EXECUTE && !skip) ? SAMPLE_CYCLES - 32'h0000_0001 : 32'h0000_0000;
      end else begin
         tick_cnt_q <= tick_cnt_q - 32'h0000_0001;
      end
   end

   always_comb begin
      dpv     = MEASURED_VALUE - pv_prev_q;
      pv_used = MEASURED_VALUE;
      pv_lim  = 1'b0;
      if (MEASUREMENT_STEP_LIMIT != '0) begin
         if (dpv > MEASUREMENT_STEP_LIMIT) begin
            pv_used = pv_prev_q + MEASUREMENT_STEP_LIMIT;
            pv_lim  = 1'b1;
         end else if (dpv < -MEASUREMENT_STEP_LIMIT) begin
            pv_used = pv_prev_q - MEASUREMENT_STEP_LIMIT;
            pv_lim  = 1'b1;
         end
      end
      err  = SETPOINT_VALUE - pv_used;
      dsrc = DERIV_ON_ERROR ? err : W'(-pv_used);
   end

   always_comb begin
      raw     = fmul(GAIN_P, err_q + i_term_q + d_term_q);
      dmv     = raw - mv_q;
      stepped = raw;
      mv_lim  = 1'b0;
      if (OUTPUT_STEP_LIMIT != '0) begin
         if (dmv > OUTPUT_STEP_LIMIT) begin
            stepped = mv_q + OUTPUT_STEP_LIMIT;
            mv_lim  = 1'b1;
         end else if (dmv < -OUTPUT_STEP_LIMIT) begin
            stepped = mv_q - OUTPUT_STEP_LIMIT;
            mv_lim  = 1'b1;
         end
      end
      mv_d   = stepped;
      at_max = 1'b0;
      at_min = 1'b0;
      // upper clamp is checked first, so it wins when both clamps apply
      if (stepped >= OUTPUT_UPPER_CLAMP) begin
         mv_d   = OUTPUT_UPPER_CLAMP;
         at_max = 1'b1;
      end else if (stepped <= OUTPUT_LOWER_CLAMP) begin
         mv_d   = OUTPUT_LOWER_CLAMP;
         at_min = 1'b1;
      end
      windup = !WINDUP_GUARD_DISABLE && ((at_max && err_q > 0) || (at_min && err_q < 0));
   end

   // divider requests: integral then derivative
   // time constants are read live here, so they must hold still within a sample
   always_comb begin
      div_bus.start = 1'b0;
      div_bus.num   = acc_cand_q;
      div_bus.den   = TIME_I;
      if (state_q == PIDC_INTEG) begin
         div_bus.start = !req_q && (TIME_I != '0);
      end else if (state_q == PIDC_DERIV) begin
         div_bus.start = !req_q && (TIME_D != '0) && (SAMPLE_TIME != '0);
         div_bus.num   = fmul(TIME_D, delta_q);
         div_bus.den   = SAMPLE_TIME;
      end
   end

   // sequencing of one sample computation
   always_ff @(posedge CLK) begin
      if (RST) begin
         state_q <= PIDC_IDLE;
         req_q   <= 1'b0;
      end else begin
         case (state_q)
            PIDC_IDLE: begin
               if (tick && GAIN_P != '0) begin
                  state_q <= PIDC_INTEG;
               end
            end
            PIDC_INTEG: begin
               if (TIME_I == '0 || (req_q && div_bus.done)) begin
                  state_q <= PIDC_DERIV;
                  req_q   <= 1'b0;
               end else if (div_bus.start) begin
                  req_q <= 1'b1;
               end
            end
            PIDC_DERIV: begin
               if (TIME_D == '0 || SAMPLE_TIME == '0 || (req_q && div_bus.done)) begin
                  state_q <= PIDC_OUTPUT;
                  req_q   <= 1'b0;
               end else if (div_bus.start) begin
                  req_q <= 1'b1;
               end
            end
            PIDC_OUTPUT: begin
               state_q <= PIDC_IDLE;
            end
            default: begin
               state_q <= PIDC_IDLE;
               req_q   <= 1'b0;
            end
         endcase
      end
   end

   // sample capture of measurement, error and derivative operand
   // the first derivative difference is taken against a zero operand
   always_ff @(posedge CLK) begin
      if (RST) begin
         pv_prev_q   <= `PIDC_RST_WORD;
         dsrc_prev_q <= `PIDC_RST_WORD;
         err_q       <= `PIDC_RST_WORD;
         delta_q     <= `PIDC_RST_WORD;
         acc_cand_q  <= `PIDC_RST_WORD;
         pv_lim_q    <= 1'b0;
      end else if (state_q == PIDC_IDLE && tick && GAIN_P != '0) begin
         pv_prev_q   <= pv_used;
         dsrc_prev_q <= dsrc;
         err_q       <= err;
         delta_q     <= dsrc - dsrc_prev_q;
         acc_cand_q  <= acc_q + fmul(err, SAMPLE_TIME);
         pv_lim_q    <= pv_lim;
      end
   end

   // term results; a zero time constant leaves its term at zero
   always_ff @(posedge CLK) begin
      if (RST) begin
         i_term_q <= `PIDC_RST_WORD;
         d_term_q <= `PIDC_RST_WORD;
      end else if (state_q == PIDC_INTEG) begin
         if (TIME_I == '0) begin
            i_term_q <= '0;
         end else if (req_q && div_bus.done) begin
            i_term_q <= div_bus.quo;
         end
      end else if (state_q == PIDC_DERIV) begin
         if (TIME_D == '0 || SAMPLE_TIME == '0) begin
            d_term_q <= '0;
         end else if (req_q && div_bus.done) begin
            d_term_q <= div_bus.quo;
         end
      end
   end

   // output, integrator and limit flags update once per sample
   always_ff @(posedge CLK) begin
      if (RST) begin
         mv_q   <= `PIDC_RST_WORD;
         acc_q  <= `PIDC_RST_WORD;
         stat_q <= `PIDC_RST_STATUS;
      end else if (!EXECUTE) begin
         stat_q <= `PIDC_RST_STATUS;
      end else if (state_q == PIDC_OUTPUT) begin
         mv_q <= mv_d;
         if (!windup) begin
            acc_q <= acc_cand_q;
         end
         stat_q                  <= `PIDC_RST_STATUS;
         stat_q[`PIDC_ST_PV_LIM] <= pv_lim_q;
         stat_q[`PIDC_ST_MV_LIM] <= mv_lim;
         stat_q[`PIDC_ST_OUTPUT_UPPER_CLAMP] <= at_max;
         stat_q[`PIDC_ST_OUTPUT_LOWER_CLAMP] <= at_min;
         stat_q[`PIDC_ST_WINDUP] <= windup;
      end else if (WINDUP_GUARD_DISABLE) begin
         stat_q[`PIDC_ST_WINDUP] <= 1'b0;
      end
   end

   // registered outputs, one process per output
   always_ff @(posedge CLK) begin
      if (RST) begin
         NORMAL_OPERATION_FLAG <= 1'b0;
      end else begin
         NORMAL_OPERATION_FLAG <= EXECUTE && !skip;
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         CONTROL_OUTPUT <= `PIDC_RST_WORD;
      end else begin
         CONTROL_OUTPUT <= mv_q;
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         STATUS <= `PIDC_RST_STATUS;
      end else begin
         STATUS                <= stat_q;
         STATUS[`PIDC_ST_SKIP] <= EXECUTE && skip;
         STATUS[`PIDC_ST_BUSY] <= EXECUTE && state_q != PIDC_IDLE;
      end
   end

endmodule : pidc_loop

// ==== dv/pidc_plant.sv ====
`timescale 1ns/1ps
module pidc_plant (
   input  wire logic               clk,
   input  wire logic               rst,
   input  wire logic               hold,
   input  wire logic signed [31:0] hold_val,
   input  wire logic signed [31:0] ctrl,
   output logic signed [31:0]      meas
);
   logic signed [31:0] meas_q;
   // held mode is a fixed sensor reading; otherwise a slow lag behind the actuator
   always_ff @(posedge clk) begin
      if (rst) begin
         meas_q <= 32'h0;
      end else if (hold) begin
         meas_q <= hold_val;
      end else begin
         meas_q <= meas_q + ((ctrl - meas_q) >>> 6);
      end
   end
   assign meas = meas_q;
endmodule : pidc_plant

// ==== dv/pidc_loop_chk.sv ====
`timescale 1ns/1ps
module pidc_loop_chk
   import pidc_pkg::*;
#(
   parameter int W = 32
) (
   input wire logic                CLK,
   input wire logic                RST,
   input wire logic                EXECUTE,
   input wire logic signed [W-1:0] OUTPUT_STEP_LIMIT,
   input wire logic signed [W-1:0] OUTPUT_UPPER_CLAMP,
   input wire logic signed [W-1:0] OUTPUT_LOWER_CLAMP,
   input wire logic                WINDUP_GUARD_DISABLE,
   input wire logic [31:0]         SAMPLE_CYCLES,
   input wire logic                NORMAL_OPERATION_FLAG,
   input wire logic [15:0]         STATUS,
   input wire logic signed [W-1:0] CONTROL_OUTPUT
);
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   logic ok_period;
   assign ok_period = SAMPLE_CYCLES >= 32'h0000_0068;
   flag_tracks_a: assert property (1'b1 |=> NORMAL_OPERATION_FLAG == $past(EXECUTE && ok_period))
      else $error("flag does not follow run enable");
   skip_bit_a: assert property ((EXECUTE && !ok_period) [*2] |=> STATUS[0] && !NORMAL_OPERATION_FLAG)
      else $error("short period not reported");
   status_idle_a: assert property (!EXECUTE [*3] |-> STATUS == 16'h0000)
      else $error("status not cleared while stopped");
   clamp_upper_a: assert property ($changed(CONTROL_OUTPUT) |-> CONTROL_OUTPUT <= OUTPUT_UPPER_CLAMP)
      else $error("output above upper clamp");
   clamp_lower_a: assert property ($changed(CONTROL_OUTPUT) |-> CONTROL_OUTPUT >= OUTPUT_LOWER_CLAMP)
      else $error("output below lower clamp");
   upper_flag_a: assert property (STATUS[4] && !STATUS[3] |-> CONTROL_OUTPUT == OUTPUT_UPPER_CLAMP)
      else $error("upper clamp bit without clamped output");
   busy_bounded_a: assert property ($rose(STATUS[8]) |-> ##[1:110] !STATUS[8])
      else $error("computation runs too long");
   output_step_a: assert property ($changed(CONTROL_OUTPUT) && OUTPUT_STEP_LIMIT != 32'h0 |->
      CONTROL_OUTPUT - $past(CONTROL_OUTPUT) <= OUTPUT_STEP_LIMIT &&
      $past(CONTROL_OUTPUT) - CONTROL_OUTPUT <= OUTPUT_STEP_LIMIT) else $error("output step too large");
   guard_off_a: assert property (WINDUP_GUARD_DISABLE [*2] |=> !STATUS[15])
      else $error("anti-windup acting while disabled");
   cover property (STATUS[4]);
   cover property (STATUS[2]);
   cover property ($fell(STATUS[8]));
   cover property (STATUS[15]);
endmodule : pidc_loop_chk

// ==== dv/pidc_loop_bench.sv ====
`timescale 1ns/1ps
module pidc_loop_bench;
   import pidc_pkg::*;
   localparam logic [31:0] ONE = 32'h0001_0000;
   logic               clk = 1'b0, rst = 1'b1, ex = 1'b0, wgd = 1'b0, doe = 1'b0, hold = 1'b1;
   logic signed [31:0] sp = 32'h0, hv = 32'h0, gp = 32'h0, ti = 32'h0, td = 32'h0, st = 32'h0;
   logic signed [31:0] osl = 32'h0, msl = 32'h0, ouc = 32'h0, olc = 32'h0, meas, mv;
   logic [31:0]        scyc = 32'h0;
   logic [15:0]        stat;
   logic               flag;
   int                 err_total = 0, n_tests = 0, cyc = 0;
   always #5 clk = ~clk;
   pidc_loop pidc_loop_inst (.CLK(clk), .RST(rst), .EXECUTE(ex), .SETPOINT_VALUE(sp), .MEASURED_VALUE(meas),
      .GAIN_P(gp), .TIME_I(ti), .TIME_D(td), .OUTPUT_STEP_LIMIT(osl), .OUTPUT_UPPER_CLAMP(ouc),
      .OUTPUT_LOWER_CLAMP(olc), .MEASUREMENT_STEP_LIMIT(msl), .WINDUP_GUARD_DISABLE(wgd),
      .DERIV_ON_ERROR(doe), .SAMPLE_CYCLES(scyc), .SAMPLE_TIME(st), .NORMAL_OPERATION_FLAG(flag),
      .STATUS(stat), .CONTROL_OUTPUT(mv));
   pidc_plant pidc_plant_inst (.clk(clk), .rst(rst), .hold(hold), .hold_val(hv), .ctrl(mv), .meas(meas));
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : stop_test
   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic dflt();
      @(posedge clk);
      {sp, hv, ti, td, osl, msl} <= {6{32'h0}};
      {wgd, doe, hold} <= 3'h1;
      gp <= ONE;
      st <= ONE;
      ouc <= 32'h000a_0000;
      olc <= 32'hfff6_0000;
      scyc <= 32'h0000_0078;
   endtask : dflt
   task automatic restart();
      @(posedge clk) rst <= 1'b1;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
   endtask : restart
   // one result after the first tick, a second one period later, then a stop
   task automatic trial(string name, logic [31:0] mv1, logic [31:0] mv2, logic [15:0] st1);
      logic busy;
      restart();
      busy = (ti != 32'h0 || td != 32'h0) && gp != 32'h0 && !st1[0];
      @(posedge clk) ex <= 1'b1;
      repeat (30) @(posedge clk);
      #1 check({name, " busy"}, {31'h0, stat[8]}, {31'h0, busy});
      repeat (82) @(posedge clk);
      #1 check({name, " output"}, mv, mv1);
      check({name, " status"}, {16'h0, stat}, {16'h0, st1});
      check({name, " flag"}, {31'h0, flag}, {31'h0, ~st1[0]});
      repeat (120) @(posedge clk);
      #1 check({name, " output two"}, mv, mv2);
      @(posedge clk) ex <= 1'b0;
      repeat (3) @(posedge clk);
      #1 check({name, " idle status"}, {16'h0, stat}, 32'h0);
      check({name, " held output"}, mv, mv2);
      $display("test %s done", name);
   endtask : trial
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         stop_test();
      end
   end
   initial begin
      dflt();
      sp <= 32'h0002_0000;
      trial("prop", 32'h0002_0000, 32'h0002_0000, 16'h0000);
      dflt();
      {gp, sp} <= {32'h0002_0000, 32'h0001_8000};
      trial("gain", 32'h0003_0000, 32'h0003_0000, 16'h0000);
      dflt();
      {gp, sp} <= {32'h0, 32'h0002_0000};
      trial("zero gain", 32'h0, 32'h0, 16'h0000);
      dflt();
      {ouc, wgd, sp} <= {ONE, 1'b1, 32'h0002_0000};
      trial("upper", ONE, ONE, 16'h0010);
      dflt();
      {olc, wgd, sp} <= {32'hffff_0000, 1'b1, 32'hfffe_0000};
      trial("lower", 32'hffff_0000, 32'hffff_0000, 16'h0020);
      dflt();
      {ti, sp} <= {32'h0002_0000, ONE};
      trial("integral", 32'h0001_8000, 32'h0002_0000, 16'h0000);
      dflt();
      {td, doe, sp, st} <= {ONE, 1'b1, ONE, 32'h0002_0000};
      trial("deriv error", 32'h0001_8000, ONE, 16'h0000);
      dflt();
      {td, sp, hv} <= {32'h0002_0000, 32'h0002_0000, ONE};
      trial("deriv measure", 32'hffff_0000, ONE, 16'h0000);
      dflt();
      {msl, hv} <= {32'h0000_8000, 32'h0002_0000};
      trial("meas step", 32'hffff_8000, 32'hffff_0000, 16'h0004);
      dflt();
      {osl, sp} <= {32'h0000_8000, 32'h0002_0000};
      trial("out step", 32'h0000_8000, ONE, 16'h0008);
      dflt();
      {scyc, sp} <= {32'h0000_0032, ONE};
      trial("short period", 32'h0, 32'h0, 16'h0001);
      dflt();
      {hold, ouc, ti, sp} <= {1'b0, ONE, ONE, 32'h0002_0000};
      restart();
      @(posedge clk) ex <= 1'b1;
      repeat (699) @(posedge clk);
      #1 check("closed output", mv, ONE);
      check("closed status", {16'h0, stat}, 32'h0000_8010);
      @(posedge clk) ex <= 1'b0;
      repeat (3) @(posedge clk);
      $display("test closed loop done");
      stop_test();
   end
endmodule : pidc_loop_bench
bind pidc_loop pidc_loop_chk #(.W(W)) pidc_loop_chk_inst (.CLK, .RST, .EXECUTE, .OUTPUT_STEP_LIMIT,
   .OUTPUT_UPPER_CLAMP, .OUTPUT_LOWER_CLAMP, .WINDUP_GUARD_DISABLE, .SAMPLE_CYCLES, .NORMAL_OPERATION_FLAG,
   .STATUS, .CONTROL_OUTPUT);
